// *** verilog/p8et_core.sv ***
/*
 * Instruction issue and execution-timing sequencer with run control,
 * breakpoint, watchpoint, debug memory access and data-move steering.
 * Assumes a fetch unit on SYS_CLK that presents one opcode with its address
 * and a branch condition unit that drives COND_TAKEN in the last base cycle.
 */
//
// Overview of operation
// - All timing counted in single system clocks, no machine cycles.
// - Most instructions take as many clocks as they have bytes.
// - Untaken conditional branch completes one clock sooner than taken.
// - No instruction exceeds eight clocks; divide takes exactly eight.
// - Opcodes, addressing and flag effects match the classic set.
// - Add, carry add, inc, dec on accumulator or register: 1 byte, 1 clock.
// - Arithmetic, inc, dec on direct byte: 2 bytes, 2 clocks.
// - Indirect RAM arithmetic, inc, dec: 1 byte but 2 clocks.
// - Immediate add, carry add, borrow subtract: 2 bytes, 2 clocks.
// - Borrow subtract of register and pointer increment: 1 byte, 1 clock.
// - 109 instructions spread over fixed clock-count groups.
// - Peak rate of one instruction per clock, 25 MIPS at 25 MHz.
// - Data move writes address flash when program store control selects it.
// - Data move reaches mapped RAM when external space is selected.
// - Software reads flash by code move, writes flash by data move.
// - Serial test port gives host flash programming and debug access.
// - Breakpoints, watchpoints, halt, run, step, register and memory access.
// - Debug runs at full speed using no application resources.
`timescale 1ns/10ps
module p8et_core import p8et_pkg::*; (
	input  wire logic        SYS_CLK,
	input  wire logic        SRST,
	input  wire logic        OP_VALID,
	output logic             OP_READY,
	input  wire logic [7:0]  OP_CODE,
	input  wire logic [15:0] OP_ADDR,
	input  wire logic        COND_TAKEN,
	output logic             RETIRE,
	output logic      [1:0]  INSN_BYTES,
	output logic      [3:0]  INSN_CLOCKS,
	output logic      [3:0]  LAST_CLOCKS,
	input  wire logic [1:0]  PROGRAM_STORE_CONTROL,
	output logic             FLASH_WR_STB,
	output logic             XRAM_WR_STB,
	output logic             XRAM_RD_STB,
	output logic             CODE_RD_STB,
	input  wire logic        DATA_ACCESS,
	input  wire logic [15:0] DATA_ADDR,
	input  wire logic        DBG_SCK,
	input  wire logic        DBG_SDI,
	input  wire logic        DBG_CS_N,
	output logic             DBG_SDO,
	output logic             DBG_MEM_REQ,
	output logic             DBG_MEM_WE,
	output logic      [1:0]  DBG_MEM_SPACE,
	output logic      [15:0] DBG_MEM_ADDR,
	output logic      [7:0]  DBG_MEM_WDATA,
	input  wire logic        DBG_MEM_ACK,
	input  wire logic [7:0]  DBG_MEM_RDATA,
	output logic             HALTED
);
	logic [1:0]  lk_bytes;
	logic [3:0]  lk_clocks;
	logic        lk_cond, lk_xwr, lk_xrd, lk_crd;
	logic        dbg_valid;
	logic [7:0]  dbg_cmd;
	logic [15:0] dbg_arg;
	logic [7:0]  dbg_data;
	logic [15:0] dbg_resp;
	logic [3:0]  dop;
	p8et_state_t state_reg;
	logic        step_pend_reg, skip_reg;
	logic        busy_reg, cond_reg, ext_reg;
	logic [3:0]  left_reg, used_reg;
	logic        bp_en_reg, wp_en_reg, bp_hit_reg, wp_hit_reg;
	logic [15:0] bp_addr_reg, wp_addr_reg;
	logic        mem_pend_reg;
	logic [7:0]  rdata_reg;
	logic        extend_w, retire_w, slot_w, issue_ok_w;
	logic        bp_match_w, wp_match_w, accept_w;
	logic        cmd_halt, cmd_run, cmd_step;

	// ************************************************************
	// Decode and debug port
	// ************************************************************
	p8et_timing u_timing (
		.opcode  (OP_CODE),
		.bytes   (lk_bytes),
		.clocks  (lk_clocks),
		.is_cond (lk_cond),
		.is_xwr  (lk_xwr),
		.is_xrd  (lk_xrd),
		.is_crd  (lk_crd)
	);

	p8et_dbg_port u_dbg (
		.clk       (SYS_CLK),
		.srst      (SRST),
		.sck_pin   (DBG_SCK),
		.sdi_pin   (DBG_SDI),
		.csn_pin   (DBG_CS_N),
		.resp      (dbg_resp),
		.sdo       (DBG_SDO),
		.cmd_valid (dbg_valid),
		.cmd       (dbg_cmd),
		.arg       (dbg_arg),
		.wdata     (dbg_data)
	);

	assign dop      = dbg_cmd[CMD_OP_MSB:0];
	assign cmd_halt = dbg_valid && (dop == CMD_HALT);
	assign cmd_run  = dbg_valid && (dop == CMD_RUN);
	assign cmd_step = dbg_valid && (dop == CMD_STEP);

	// ************************************************************
	// Issue slot
	// ************************************************************
	// Taken branch stretches the last base cycle by exactly one clock
	assign extend_w   = busy_reg && (left_reg == CLK_ONE) && cond_reg && !ext_reg && COND_TAKEN;
	assign retire_w   = busy_reg && (left_reg == CLK_ONE) && !extend_w;
	assign slot_w     = !busy_reg || retire_w;
	assign issue_ok_w = (state_reg == ST_RUN) || step_pend_reg;
	assign bp_match_w = bp_en_reg && OP_VALID && (OP_ADDR == bp_addr_reg) && !skip_reg
	                    && (state_reg == ST_RUN) && slot_w;
	assign wp_match_w = wp_en_reg && DATA_ACCESS && (DATA_ADDR == wp_addr_reg);
	assign OP_READY   = slot_w && issue_ok_w && !bp_match_w;
	assign accept_w   = OP_VALID && OP_READY;
	assign RETIRE     = retire_w;
	assign HALTED     = (state_reg == ST_HALT);

	// ************************************************************
	// Run control
	// ************************************************************
	always_ff @(posedge SYS_CLK) begin
		if (SRST)
			state_reg <= ST_RUN;
		else if (cmd_halt || bp_match_w || wp_match_w)
			state_reg <= ST_HALT;
		else if (cmd_run)
			state_reg <= ST_RUN;
	end

	// Stepping does not mask interrupts, so handlers step like any code
	always_ff @(posedge SYS_CLK) begin
		if (SRST)
			step_pend_reg <= 1'b0;
		else if (cmd_step && (state_reg == ST_HALT))
			step_pend_reg <= 1'b1;
		else if (accept_w || cmd_run)
			step_pend_reg <= 1'b0;
	end

	// Lets the instruction under a breakpoint go once after resuming
	always_ff @(posedge SYS_CLK) begin
		if (SRST)
			skip_reg <= 1'b0;
		else if (cmd_run || cmd_step)
			skip_reg <= 1'b1;
		else if (accept_w)
			skip_reg <= 1'b0;
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			bp_en_reg   <= 1'b0;
			bp_addr_reg <= 16'h0;
			wp_en_reg   <= 1'b0;
			wp_addr_reg <= 16'h0;
		end else if (dbg_valid) begin
			if (dop == CMD_SET_BP) begin
				bp_en_reg   <= 1'b1;
				bp_addr_reg <= dbg_arg;
			end
			if (dop == CMD_CLR_BP)
				bp_en_reg <= 1'b0;
			if (dop == CMD_SET_WP) begin
				wp_en_reg   <= 1'b1;
				wp_addr_reg <= dbg_arg;
			end
			if (dop == CMD_CLR_WP)
				wp_en_reg <= 1'b0;
		end
	end

	// Hit flags: a new hit wins over the resume that clears them
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			bp_hit_reg <= 1'b0;
			wp_hit_reg <= 1'b0;
		end else begin
			if (bp_match_w)
				bp_hit_reg <= 1'b1;
			else if (cmd_run || cmd_step)
				bp_hit_reg <= 1'b0;
			if (wp_match_w)
				wp_hit_reg <= 1'b1;
			else if (cmd_run || cmd_step)
				wp_hit_reg <= 1'b0;
		end
	end

	// ************************************************************
	// Execution counter
	// ************************************************************
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			busy_reg <= 1'b0;
			left_reg <= 4'h0;
			cond_reg <= 1'b0;
			ext_reg  <= 1'b0;
			used_reg <= 4'h0;
		end else if (accept_w) begin
			busy_reg <= 1'b1;
			left_reg <= lk_clocks;
			cond_reg <= lk_cond;
			ext_reg  <= 1'b0;
			used_reg <= CLK_ONE;
		end else if (retire_w) begin
			busy_reg <= 1'b0;
		end else if (extend_w) begin
			ext_reg  <= 1'b1;
			used_reg <= used_reg + CLK_ONE;
		end else if (busy_reg) begin
			left_reg <= left_reg - CLK_ONE;
			used_reg <= used_reg + CLK_ONE;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			INSN_BYTES  <= 2'h0;
			INSN_CLOCKS <= 4'h0;
			LAST_CLOCKS <= 4'h0;
		end else begin
			if (accept_w) begin
				INSN_BYTES  <= lk_bytes;
				INSN_CLOCKS <= lk_clocks;
			end
			if (retire_w)
				LAST_CLOCKS <= used_reg;
		end
	end

	// ************************************************************
	// Data move steering
	// ************************************************************
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			FLASH_WR_STB <= 1'b0;
			XRAM_WR_STB  <= 1'b0;
			XRAM_RD_STB  <= 1'b0;
			CODE_RD_STB  <= 1'b0;
		end else begin
			FLASH_WR_STB <= accept_w && lk_xwr && PROGRAM_STORE_CONTROL[PSC_WE_BIT];
			XRAM_WR_STB  <= accept_w && lk_xwr && !PROGRAM_STORE_CONTROL[PSC_WE_BIT];
			XRAM_RD_STB  <= accept_w && lk_xrd;
			CODE_RD_STB  <= accept_w && lk_crd;
		end
	end

	// ************************************************************
	// Debug memory access
	// ************************************************************
	// Separate port into the core, so no RAM, stack or timer is borrowed
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			DBG_MEM_REQ   <= 1'b0;
			DBG_MEM_WE    <= 1'b0;
			DBG_MEM_SPACE <= 2'h0;
			DBG_MEM_ADDR  <= 16'h0;
			DBG_MEM_WDATA <= 8'h0;
		end else begin
			DBG_MEM_REQ <= dbg_valid && ((dop == CMD_MEM_RD) || (dop == CMD_MEM_WR));
			if (dbg_valid && ((dop == CMD_MEM_RD) || (dop == CMD_MEM_WR))) begin
				DBG_MEM_WE    <= (dop == CMD_MEM_WR);
				DBG_MEM_SPACE <= dbg_cmd[CMD_SPACE_MSB:CMD_SPACE_LSB];
				DBG_MEM_ADDR  <= dbg_arg;
				DBG_MEM_WDATA <= dbg_data;
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			mem_pend_reg <= 1'b0;
			rdata_reg    <= 8'h0;
		end else begin
			if (DBG_MEM_REQ)
				mem_pend_reg <= 1'b1;
			else if (DBG_MEM_ACK)
				mem_pend_reg <= 1'b0;
			if (DBG_MEM_ACK && !DBG_MEM_WE)
				rdata_reg <= DBG_MEM_RDATA;
		end
	end

	always_comb begin
		dbg_resp                 = {8'h0, rdata_reg};
		dbg_resp[8 + STAT_HALTED] = HALTED;
		dbg_resp[8 + STAT_BP]     = bp_hit_reg;
		dbg_resp[8 + STAT_WP]     = wp_hit_reg;
		dbg_resp[8 + STAT_STEP]   = step_pend_reg;
		dbg_resp[8 + STAT_BUSY]   = busy_reg;
		dbg_resp[8 + STAT_MEM]    = mem_pend_reg;
	end

	// ************************************************************
	// Checks
	// ************************************************************
	property p_div_eight;
		@(posedge SYS_CLK) disable iff (SRST)
		(accept_w && (OP_CODE == OPC_DIV)) |=> !retire_w [*7] ##1 retire_w;
	endproperty
	a_div_eight: assert property (p_div_eight) else $error("divide not eight clocks");

	property p_max_eight;
		@(posedge SYS_CLK) disable iff (SRST)
		busy_reg |-> (used_reg <= CLK_MAX) && (used_reg != 4'h0);
	endproperty
	a_max_eight: assert property (p_max_eight) else $error("instruction over eight clocks");

	property p_reg_one;
		@(posedge SYS_CLK) disable iff (SRST)
		(accept_w && (OP_CODE[7:3] == 5'b00101)) |=> retire_w && (INSN_BYTES == 2'h1);
	endproperty
	a_reg_one: assert property (p_reg_one) else $error("register add not one clock");

	property p_direct_two;
		@(posedge SYS_CLK) disable iff (SRST)
		(accept_w && (OP_CODE == 8'h25)) |=> !retire_w ##1 retire_w ##1 (LAST_CLOCKS == 4'h2);
	endproperty
	a_direct_two: assert property (p_direct_two) else $error("direct add not two clocks");

	property p_ind_two;
		@(posedge SYS_CLK) disable iff (SRST)
		(accept_w && (OP_CODE[7:1] == 7'b0000011)) |=> (INSN_BYTES == 2'h1) && !retire_w ##1 retire_w;
	endproperty
	a_ind_two: assert property (p_ind_two) else $error("indirect increment not two clocks");

	property p_imm_two;
		@(posedge SYS_CLK) disable iff (SRST)
		(accept_w && (OP_CODE == 8'h94)) |=> (INSN_BYTES == 2'h2) && (INSN_CLOCKS == 4'h2);
	endproperty
	a_imm_two: assert property (p_imm_two) else $error("immediate subtract wrong size");

	property p_data_pointer_16_one;
		@(posedge SYS_CLK) disable iff (SRST)
		(accept_w && (OP_CODE == OPC_INC_DATA_POINTER_16)) |=> retire_w ##1 (LAST_CLOCKS == CLK_ONE);
	endproperty
	a_data_pointer_16_one: assert property (p_data_pointer_16_one) else $error("pointer increment not one clock");

	property p_taken_plus_one;
		@(posedge SYS_CLK) disable iff (SRST)
		(retire_w && ext_reg) |=> (LAST_CLOCKS == $past(INSN_CLOCKS) + CLK_ONE);
	endproperty
	a_taken_plus_one: assert property (p_taken_plus_one) else $error("taken branch not one extra clock");

	property p_untaken_base;
		@(posedge SYS_CLK) disable iff (SRST)
		(retire_w && !ext_reg) |=> (LAST_CLOCKS == $past(INSN_CLOCKS));
	endproperty
	a_untaken_base: assert property (p_untaken_base) else $error("base clock count wrong");

	property p_flash_steer;
		@(posedge SYS_CLK) disable iff (SRST)
		(accept_w && lk_xwr && PROGRAM_STORE_CONTROL[PSC_WE_BIT]) |=> FLASH_WR_STB && !XRAM_WR_STB;
	endproperty
	a_flash_steer: assert property (p_flash_steer) else $error("data move write missed flash");

	property p_xram_steer;
		@(posedge SYS_CLK) disable iff (SRST)
		(accept_w && lk_xwr && !PROGRAM_STORE_CONTROL[PSC_WE_BIT]) |=> XRAM_WR_STB && !FLASH_WR_STB;
	endproperty
	a_xram_steer: assert property (p_xram_steer) else $error("data move write missed ram");

	property p_halt_holds;
		@(posedge SYS_CLK) disable iff (SRST)
		(HALTED && !step_pend_reg) |-> !OP_READY;
	endproperty
	a_halt_holds: assert property (p_halt_holds) else $error("issue while halted");
endmodule : p8et_core

// *** verilog/p8et_pkg.sv ***
/*
 * Shared constants for the execution-timing block: cycle limits, decode
 * figures, debug frame layout and command codes, state type.
 * Assumes one 100 MHz system clock and a synchronous active-high reset.
 */
package p8et_pkg;
	// ************************************************************
	// Clock and timing
	// ************************************************************
	localparam int         SYS_CLK_MHZ  = 100;
	localparam int         FMAX_MHZ     = 25;
	localparam int         PEAK_IPC     = 1;
	localparam logic [3:0] CLK_ONE      = 4'h1;
	localparam logic [3:0] CLK_IND      = 4'h2;
	localparam logic [3:0] CLK_XMOVE    = 4'h3;
	localparam logic [3:0] CLK_MUL      = 4'h4;
	localparam logic [3:0] CLK_DIV      = 4'h8;
	localparam logic [3:0] CLK_MAX      = 4'h8;
	localparam logic [7:0] OPC_MUL      = 8'hA4;
	localparam logic [7:0] OPC_DIV      = 8'h84;
	localparam logic [7:0] OPC_INC_DATA_POINTER_16 = 8'hA3;

	// ************************************************************
	// Program store control and debug frame
	// ************************************************************
	localparam int         PSC_WE_BIT     = 0;
	localparam logic [5:0] DBG_FRAME_BITS = 6'h20;
	localparam logic [2:0] DBG_SYNC_RST   = 3'h4;
	localparam int         CMD_OP_MSB     = 3;
	localparam int         CMD_SPACE_MSB  = 5;
	localparam int         CMD_SPACE_LSB  = 4;
	localparam logic [3:0] CMD_HALT       = 4'h1;
	localparam logic [3:0] CMD_RUN        = 4'h2;
	localparam logic [3:0] CMD_STEP       = 4'h3;
	localparam logic [3:0] CMD_SET_BP     = 4'h4;
	localparam logic [3:0] CMD_CLR_BP     = 4'h5;
	localparam logic [3:0] CMD_SET_WP     = 4'h6;
	localparam logic [3:0] CMD_CLR_WP     = 4'h7;
	localparam logic [3:0] CMD_MEM_RD     = 4'h8;
	localparam logic [3:0] CMD_MEM_WR     = 4'h9;
	localparam int         STAT_HALTED    = 7;
	localparam int         STAT_BP        = 6;
	localparam int         STAT_WP        = 5;
	localparam int         STAT_STEP      = 4;
	localparam int         STAT_BUSY      = 3;
	localparam int         STAT_MEM       = 2;

	typedef enum logic [0:0] {ST_RUN, ST_HALT} p8et_state_t;
endpackage : p8et_pkg

// *** verilog/p8et_timing.sv ***
/*
 * Opcode length and clock-count lookup, purely combinational.
 * Assumes the opcode byte is stable in the cycle it is looked up.
 */
`timescale 1ns/10ps
module p8et_timing import p8et_pkg::*; (
	input  wire logic [7:0] opcode,
	output logic      [1:0] bytes,
	output logic      [3:0] clocks,
	output logic            is_cond,
	output logic            is_xwr,
	output logic            is_xrd,
	output logic            is_crd
);
	// ************************************************************
	// Length and base clocks from the classic encoding
	// ************************************************************
	always_comb begin
		bytes = 2'h1;
		casez (opcode)
			8'h?1 : bytes = 2'h2;
			8'h02, 8'h12, 8'h10, 8'h20, 8'h30, 8'h90, 8'h43, 8'h53, 8'h63,
			8'h75, 8'h85, 8'hB4, 8'hB5, 8'hD5, 8'hB6, 8'hB7, 8'b1011_1??? : bytes = 2'h3;
			8'h40, 8'h50, 8'h60, 8'h70, 8'h80, 8'hA0, 8'hB0, 8'hC0, 8'hD0,
			8'h42, 8'h52, 8'h62, 8'h72, 8'h82, 8'h92, 8'hA2, 8'hB2, 8'hC2, 8'hD2,
			8'h24, 8'h34, 8'h44, 8'h54, 8'h64, 8'h74, 8'h94,
			8'h05, 8'h15, 8'h25, 8'h35, 8'h45, 8'h55, 8'h65, 8'h95, 8'hC5, 8'hE5, 8'hF5,
			8'h76, 8'h77, 8'h86, 8'h87, 8'hA6, 8'hA7,
			8'b0111_1???, 8'b1000_1???, 8'b1010_1???, 8'b1101_1??? : bytes = 2'h2;
			default : bytes = 2'h1;
		endcase
	end

	// Clocks follow length except where the pipeline stalls
	always_comb begin
		clocks = {2'h0, bytes};
		casez (opcode)
			OPC_MUL : clocks = CLK_MUL;
			OPC_DIV : clocks = CLK_DIV;
			8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3, 8'h83, 8'h93 : clocks = CLK_XMOVE;
			8'b0??0_011?, 8'b0?01_011?, 8'b0011_011?, 8'h96, 8'h97, 8'hE6, 8'hE7 : clocks = CLK_IND;
			default : clocks = {2'h0, bytes};
		endcase
	end

	always_comb begin
		casez (opcode)
			8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60, 8'h70, 8'hB4, 8'hB5, 8'hB6, 8'hB7,
			8'hD5, 8'b1011_1???, 8'b1101_1??? : is_cond = 1'b1;
			default : is_cond = 1'b0;
		endcase
	end

	assign is_xwr = (opcode == 8'hF0) || (opcode == 8'hF2) || (opcode == 8'hF3);
	assign is_xrd = (opcode == 8'hE0) || (opcode == 8'hE2) || (opcode == 8'hE3);
	assign is_crd = (opcode == 8'h83) || (opcode == 8'h93);
endmodule : p8et_timing

// *** verilog/p8et_dbg_port.sv ***
/*
 * Serial debug access port: synchronises the three host pins, shifts a
 * 32-bit command frame in and a 16-bit answer out.
 * Assumes host pins are asynchronous and the host clock is far below 25 MHz.
 */
`timescale 1ns/10ps
module p8et_dbg_port import p8et_pkg::*; (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        sck_pin,
	input  wire logic        sdi_pin,
	input  wire logic        csn_pin,
	input  wire logic [15:0] resp,
	output logic             sdo,
	output logic             cmd_valid,
	output logic      [7:0]  cmd,
	output logic      [15:0] arg,
	output logic      [7:0]  wdata
);
	logic [2:0]  pin_raw;
	logic [2:0]  meta_reg;
	logic [2:0]  sync_reg;
	logic [2:0]  prev_reg;
	logic [31:0] in_sh_reg;
	logic [15:0] out_sh_reg;
	logic [5:0]  cnt_reg;
	logic        sck_rise, sck_fall, cs_act, cs_fall, cs_rise;

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	assign pin_raw = {csn_pin, sdi_pin, sck_pin};
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge clk) begin
				if (srst) begin
					meta_reg[gi] <= DBG_SYNC_RST[gi];
					sync_reg[gi] <= DBG_SYNC_RST[gi];
				end else begin
					meta_reg[gi] <= pin_raw[gi];
					sync_reg[gi] <= meta_reg[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (srst)
			prev_reg <= DBG_SYNC_RST;
		else
			prev_reg <= sync_reg;
	end

	assign sck_rise = sync_reg[0] && !prev_reg[0];
	assign sck_fall = !sync_reg[0] && prev_reg[0];
	assign cs_act   = !sync_reg[2];
	assign cs_fall  = !sync_reg[2] && prev_reg[2];
	assign cs_rise  = sync_reg[2] && !prev_reg[2];

	// ************************************************************
	// Frame shifting
	// ************************************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			in_sh_reg  <= 32'h0;
			out_sh_reg <= 16'h0;
			cnt_reg    <= 6'h0;
			sdo        <= 1'b0;
		end else if (cs_fall) begin
			out_sh_reg <= {resp[14:0], 1'b0};
			sdo        <= resp[15];
			cnt_reg    <= 6'h0;
		end else if (cs_act && sck_rise) begin
			in_sh_reg <= {in_sh_reg[30:0], sync_reg[1]};
			if (cnt_reg != DBG_FRAME_BITS)
				cnt_reg <= cnt_reg + 6'h1;
		end else if (cs_act && sck_fall) begin
			sdo        <= out_sh_reg[15];
			out_sh_reg <= {out_sh_reg[14:0], 1'b0};
		end
	end

	// Short frames are dropped so a glitched select cannot fire a command
	always_ff @(posedge clk) begin
		if (srst) begin
			cmd_valid <= 1'b0;
			cmd       <= 8'h0;
			arg       <= 16'h0;
			wdata     <= 8'h0;
		end else begin
			cmd_valid <= cs_rise && (cnt_reg == DBG_FRAME_BITS);
			if (cs_rise && (cnt_reg == DBG_FRAME_BITS)) begin
				cmd   <= in_sh_reg[31:24];
				arg   <= in_sh_reg[23:8];
				wdata <= in_sh_reg[7:0];
			end
		end
	end
endmodule : p8et_dbg_port

// *** dv/p8et_host.sv ***
/*
 * Debug host model: shifts 32-bit command frames into the serial test port
 * and collects the 16-bit answer.
 * Assumes SYS_CLK at 100 MHz; port pins pass through two-flop synchronisers.
 */
`timescale 1ns/10ps
module p8et_host (
	input  wire logic clk,
	input  wire logic sdo,
	output logic      sck,
	output logic      sdi,
	output logic      cs_n
);
	logic [15:0] resp;
	initial begin
		sck = 1'b0;
		sdi = 1'b0;
		cs_n = 1'b1;
	end
	// Data line means nothing between frames, so keep it moving
	always @(negedge clk) begin
		if (cs_n) begin
			sdi <= ~sdi;
		end
	end
	// ************************************************************
	// Frame: four clocks per phase keeps both clock halves long enough
	// ************************************************************
	task automatic frame(input logic [31:0] f);
		@(negedge clk);
		cs_n = 1'b0;
		repeat (4) @(negedge clk);
		for (int i = 31; i >= 0; i--) begin
			sdi = f[i];
			repeat (4) @(negedge clk);
			if (i > 15) begin
				resp[i-16] = sdo;
			end
			sck = 1'b1;
			repeat (4) @(negedge clk);
			sck = 1'b0;
		end
		repeat (4) @(negedge clk);
		cs_n = 1'b1;
		repeat (12) @(negedge clk);
	endtask : frame
endmodule : p8et_host

// *** dv/testbench.sv ***
/*
 * Self-checking bench: opcode timing, branch timing, data-move steering
 * and debug control of the core through the host model.
 * Assumes the package and core are compiled first.
 */
`timescale 1ns/10ps
module testbench import p8et_pkg::*;;
	logic SYS_CLK = 1'b0, SRST = 1'b1, OP_VALID = 1'b0, COND_TAKEN = 1'b0, DATA_ACCESS = 1'b0;
	logic DBG_MEM_ACK = 1'b0, OP_READY, RETIRE, HALTED, DBG_SDO, DBG_MEM_REQ, DBG_MEM_WE;
	logic DBG_SCK, DBG_SDI, DBG_CS_N, FLASH_WR_STB, XRAM_WR_STB, XRAM_RD_STB, CODE_RD_STB;
	logic [7:0]  OP_CODE = 8'h00, DBG_MEM_RDATA = 8'h00, DBG_MEM_WDATA;
	logic [15:0] OP_ADDR = 16'h0000, DATA_ADDR = 16'h0000, DBG_MEM_ADDR;
	logic [1:0]  PROGRAM_STORE_CONTROL = 2'h0, INSN_BYTES, DBG_MEM_SPACE;
	logic [3:0]  INSN_CLOCKS, LAST_CLOCKS;
	int          n_mismatch = 0, compares = 0, n_ret = 0;
	logic [7:0]  ops [12] = '{8'h28, 8'h26, 8'h24, 8'h98, 8'h96, 8'hA3, 8'hA4, 8'h84, 8'h94, 8'h36, 8'h25, 8'h06};
	logic [3:0]  hi [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h9};

	always #5 SYS_CLK = ~SYS_CLK;
	p8et_core p8et_core_inst (.SYS_CLK, .SRST, .OP_VALID, .OP_READY, .OP_CODE, .OP_ADDR, .COND_TAKEN,
		.RETIRE, .INSN_BYTES, .INSN_CLOCKS, .LAST_CLOCKS, .PROGRAM_STORE_CONTROL, .FLASH_WR_STB,
		.XRAM_WR_STB, .XRAM_RD_STB, .CODE_RD_STB, .DATA_ACCESS, .DATA_ADDR, .DBG_SCK, .DBG_SDI,
		.DBG_CS_N, .DBG_SDO, .DBG_MEM_REQ, .DBG_MEM_WE, .DBG_MEM_SPACE, .DBG_MEM_ADDR,
		.DBG_MEM_WDATA, .DBG_MEM_ACK, .DBG_MEM_RDATA, .HALTED);
	p8et_host p8et_host_inst (.clk(SYS_CLK), .sdo(DBG_SDO), .sck(DBG_SCK), .sdi(DBG_SDI), .cs_n(DBG_CS_N));

	always @(posedge SYS_CLK) n_ret <= n_ret + int'(RETIRE);
	// Memory answers late, with a value tied to the address
	initial forever begin
		@(posedge SYS_CLK iff DBG_MEM_REQ === 1'b1);
		repeat ($urandom_range(4, 1)) @(negedge SYS_CLK);
		DBG_MEM_ACK = 1'b1;
		DBG_MEM_RDATA = DBG_MEM_ADDR[7:0] ^ 8'hA5;
		@(negedge SYS_CLK);
		DBG_MEM_ACK = 1'b0;
		DBG_MEM_RDATA = ~DBG_MEM_RDATA;
	end

	// ************************************************************
	// Expectation, check and closing helpers
	// ************************************************************
	function automatic logic [7:0] exp_t(input logic [7:0] op); // bytes, clocks
		case (op)
			8'hA3: return 8'h11;
			8'hA4: return 8'h14;
			8'h84: return 8'h18;
			8'h60: return 8'h22;
			8'hF0, 8'hE0, 8'h93: return 8'h13;
			default: ;
		endcase
		if (op[3]) return 8'h11;
		if (op[3:0] == 4'h4) return (op[7:5] == 3'h0) ? 8'h11 : 8'h22;
		return (op[3:0] == 4'h5) ? 8'h22 : 8'h12;
	endfunction : exp_t
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic end_sim();
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim
	task automatic do_op(input logic [7:0] op, input logic tk, output logic [3:0] stb);
		int n;
		logic [7:0] e;
		e = exp_t(op);
		@(negedge SYS_CLK);
		{OP_VALID, OP_CODE, OP_ADDR, COND_TAKEN} = {1'b1, op, 16'($urandom), tk};
		n = 0;
		while (OP_READY !== 1'b1 && n < 20) begin
			@(negedge SYS_CLK);
			n++;
		end
		@(negedge SYS_CLK);
		OP_VALID = 1'b0;
		stb = {FLASH_WR_STB, XRAM_WR_STB, XRAM_RD_STB, CODE_RD_STB};
		chk({2'h0, INSN_BYTES, INSN_CLOCKS}, {2'h0, e[5:4], e[3:0]}, "length");
		n = 1;
		while (RETIRE !== 1'b1 && n < 20) begin
			@(negedge SYS_CLK);
			n++;
		end
		chk(8'(n), {4'h0, e[3:0] + {3'h0, tk}}, "clocks");
		@(negedge SYS_CLK);
		chk({4'h0, LAST_CLOCKS}, {4'h0, e[3:0] + {3'h0, tk}}, "last clocks");
	endtask : do_op

	initial begin
		#200us;
		n_mismatch++;
		end_sim();
	end

	initial begin
		logic [3:0] s;
		logic [7:0] op;
		void'($urandom(62200));
		repeat (10) @(negedge SYS_CLK);
		SRST = 1'b0;
		foreach (ops[i]) do_op(ops[i], 1'b0, s);
		repeat (40) do_op({hi[$urandom_range(4)], 4'($urandom_range(15, 4))}, 1'b0, s);
		do_op(8'h60, 1'b0, s);
		do_op(8'h60, 1'b1, s);
		PROGRAM_STORE_CONTROL = 2'h1;
		do_op(8'hF0, 1'b0, s);
		chk({4'h0, s}, 8'h08, "flash write");
		PROGRAM_STORE_CONTROL = 2'h2;
		do_op(8'hF0, 1'b0, s);
		chk({4'h0, s}, 8'h04, "ram write");
		do_op(8'hE0, 1'b0, s);
		chk({4'h0, s}, 8'h02, "ram read");
		do_op(8'h93, 1'b0, s);
		chk({4'h0, s}, 8'h01, "code read");
		{OP_VALID, OP_CODE, op} = {1'b1, 8'h28, 8'(n_ret)};
		repeat (6) @(negedge SYS_CLK);
		OP_VALID = 1'b0;
		repeat (3) @(negedge SYS_CLK);
		chk(8'(n_ret) - op, 8'h06, "back to back");
		p8et_host_inst.frame({4'h0, CMD_HALT, 24'h0});
		chk({7'h0, HALTED}, 8'h01, "halt");
		{OP_VALID, op} = {1'b1, 8'(n_ret)};
		repeat (5) @(negedge SYS_CLK);
		chk({7'h0, OP_READY}, 8'h00, "held");
		p8et_host_inst.frame({4'h0, CMD_STEP, 24'h0});
		chk({6'h0, p8et_host_inst.resp[15], HALTED}, 8'h03, "step status");
		chk(8'(n_ret) - op, 8'h01, "one step");
		p8et_host_inst.frame({4'h0, CMD_RUN, 24'h0});
		OP_VALID = 1'b0;
		chk({7'h0, HALTED}, 8'h00, "run");
		p8et_host_inst.frame({4'h0, CMD_SET_BP, 24'h123400});
		{OP_VALID, OP_ADDR} = {1'b1, 16'h1234};
		repeat (6) @(negedge SYS_CLK);
		chk({6'h0, HALTED, OP_READY}, 8'h02, "breakpoint");
		p8et_host_inst.frame({4'h0, CMD_CLR_BP, 24'h0});
		chk({6'h0, p8et_host_inst.resp[15:14]}, 8'h03, "break status");
		p8et_host_inst.frame({4'h0, CMD_RUN, 24'h0});
		OP_VALID = 1'b0;
		op = 8'($urandom);
		p8et_host_inst.frame({4'h1, CMD_MEM_WR, 8'h40, op, op});
		chk(DBG_MEM_WDATA ^ DBG_MEM_ADDR[7:0], 8'h00, "mem write");
		chk(DBG_MEM_ADDR[15:8], 8'h40, "mem address");
		chk({5'h0, DBG_MEM_WE, DBG_MEM_SPACE}, 8'h05, "mem kind");
		p8et_host_inst.frame({4'h1, CMD_MEM_RD, 8'h41, op, 8'h00});
		p8et_host_inst.frame(32'h0);
		chk(p8et_host_inst.resp[7:0], op ^ 8'hA5, "mem read");
		p8et_host_inst.frame({4'h0, CMD_SET_WP, 24'h0BEE00});
		{DATA_ACCESS, DATA_ADDR} = {1'b1, 16'h0BEE};
		@(negedge SYS_CLK);
		DATA_ACCESS = 1'b0;
		chk({7'h0, HALTED}, 8'h01, "watchpoint");
		p8et_host_inst.frame({4'h0, CMD_CLR_WP, 24'h0});
		chk({6'h0, p8et_host_inst.resp[15], p8et_host_inst.resp[13]}, 8'h03, "watch status");
		end_sim();
	end
endmodule : testbench
